/* File: fpec_pkg.sv */
`default_nettype none
package fpec_pkg;
	// register byte offsets on the apb window
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_INDEX = 8'h04;
	localparam logic [7:0] OFS_PARAM = 8'h08;
	localparam logic [7:0] OFS_AVAIL = 8'h0c;
	localparam logic [7:0] OFS_PROT_LO = 8'h10;
	localparam logic [7:0] OFS_PROT_HI = 8'h14;
	localparam logic [7:0] OFS_PROT_CTL = 8'h18;
	localparam logic [7:0] OFS_SECURITY = 8'h1c;
	// flash_status_reg bit positions
	localparam int unsigned ST_CMD_COMPLETE_FLAG = 7;
	localparam int unsigned ST_ACCESS_ERROR_FLAG = 5;
	localparam int unsigned ST_PROTECTION_VIOLATION_FLAG = 4;
	localparam int unsigned ST_MG1 = 1;
	localparam int unsigned ST_MG0 = 0;
	// avail and prot_ctl bit positions
	localparam int unsigned AV_PROG = 0;
	localparam int unsigned AV_ONCE = 1;
	localparam int unsigned AV_ERALL = 2;
	localparam int unsigned PC_PFLASH = 0;
	localparam int unsigned PC_DFLASH = 1;
	localparam logic [2:0] AVAIL_RST = 3'h7;
	localparam logic [1:0] PROT_CTL_RST = 2'h0;
	localparam logic [17:0] PROT_LO_RST = 18'h00000;
	localparam logic [17:0] PROT_HI_RST = 18'h00000;
	// command codes and indexed parameter slots
	localparam logic [7:0] CMD_PROG = 8'h06;
	localparam logic [7:0] CMD_ONCE = 8'h07;
	localparam logic [7:0] CMD_ERALL = 8'h08;
	localparam logic [2:0] IDX_CODE = 3'h0;
	localparam logic [2:0] IDX_LAST = 3'h5;
	localparam int unsigned PARAM_WORDS = 6;
	localparam logic [15:0] ONCE_LAST = 16'h0007;
	// program flash global address window
	localparam logic [17:0] PF_LO = 18'h30000;
	localparam logic [17:0] PF_HI = 18'h3ffff;
	localparam logic [63:0] ERASED_PHRASE = 64'hffff_ffff_ffff_ffff;
	typedef enum logic [1:0] {FOP_READ, FOP_PROG, FOP_ERASE_ALL, FOP_BLANK_ALL} fpec_fop_t;
	typedef enum logic [2:0] {
		SQ_IDLE = 3'b000,
		SQ_BLANK = 3'b001,
		SQ_PROG = 3'b011,
		SQ_VERIFY = 3'b010,
		SQ_ERASE = 3'b110,
		SQ_EVERIFY = 3'b111
	} fpec_state_t;
	typedef struct packed {
		logic valid;
		fpec_fop_t fop;
		logic ifr;
		logic [17:0] addr;
		logic [63:0] wdata;
	} fpec_freq_t;
	typedef struct packed {
		logic ack;
		logic [63:0] rdata;
		logic err;
		logic uncorr;
	} fpec_frsp_t;
endpackage
`default_nettype wire

/* File: fpec_seq.sv */
// Notes on behaviour
// R1: software loads code 06, address and four data words at indices 0 to 5.
// R2: software supplies a phrase address with low three bits zero.
// R3: launch programs four words, reads them back, then sets cmd_complete_flag.
// R4: program and write-once raise access error unless index is 5 at launch.
// R5: a command disabled in the current mode raises access error.
// R6: program address outside program flash raises access error.
// R7: program address not phrase aligned raises access error.
// R8: program address inside protected range raises protection violation.
// R9: any verify mismatch or read fault sets verify_error_flag.
// R10: non-correctable verify read error sets uncorrectable_error_flag.
// R11: software loads code 07, phrase index 0..7 and four data words.
// R12: write-once checks blank, programs, verifies; complete flag stays low meanwhile.
// R13: write-once phrase index above 7 raises access error.
// R14: write-once of an already programmed phrase is refused with access error.
// R15: a phrase still reading all ones may be written once again.
// R16: program flash reads return invalid data during write-once.
// R17: software never runs write-once from the block holding the field.
// R18: software programs only erased phrases, never cumulatively.
// R19: erase-everything is code 08 and raises access error unless index is 0.
// R20: erase-everything erases, verifies, and releases security only on clean verify.
// R21: erase-everything with any protection enabled raises protection violation.
// R22: software writes no register while erase-everything runs.
// R23: a launch with access or protection error starts nothing, completes at once.
`timescale 1ns/1ps
`default_nettype none
module fpec_seq
	import fpec_pkg::*;
(
	input wire logic pclk, // bus clock
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [31:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	output fpec_pkg::fpec_freq_t fl_req, // request to flash array
	input wire fpec_pkg::fpec_frsp_t fl_rsp, // answer from flash array
	output logic pf_read_invalid, // program flash reads must be poisoned
	output logic secured // security state
);
	import fpec_pkg::*;

	fpec_state_t state_r, state_nxt;
	logic cmd_complete_flag_r, access_error_flag_r, protection_violation_flag_r, mg1_r, mg0_r, secured_r, once_r, once_nxt;
	logic [2:0] idx_r, avail_r;
	logic [15:0] param_r [PARAM_WORDS];
	logic [17:0] prot_lo_r, prot_hi_r;
	logic [1:0] prot_ctl_r;
	logic [17:0] addr_r;
	logic [63:0] wdata_r;
	fpec_freq_t req_r;

	logic acc_phase, wr_en, hit;
	logic [7:0] ofs;
	logic [7:0] code;
	logic [17:0] gaddr;
	logic pf_valid, prot_hit, chk_acc, chk_fpv, launch, launch_ok;
	logic blank_ok, verify_bad, ever_bad;

	assign acc_phase = psel & penable;
	assign ofs = paddr[7:0];
	assign wr_en = acc_phase & pwrite & hit;
	assign pready = 1'b1;
	assign pslverr = acc_phase & ~hit;

	always_comb
	begin
		hit = 1'b0;
		if (paddr[31:8] == 24'h000000 && paddr[1:0] == 2'b00)
		begin
			unique case (ofs)
				OFS_STATUS, OFS_INDEX, OFS_PARAM, OFS_AVAIL,
				OFS_PROT_LO, OFS_PROT_HI, OFS_PROT_CTL, OFS_SECURITY: hit = 1'b1;
				default: hit = 1'b0;
			endcase
		end
	end

	always_comb
	begin
		prdata = 32'h00000000;
		unique case (ofs)
			OFS_STATUS:
			begin
				prdata[ST_CMD_COMPLETE_FLAG] = cmd_complete_flag_r;
				prdata[ST_ACCESS_ERROR_FLAG] = access_error_flag_r;
				prdata[ST_PROTECTION_VIOLATION_FLAG] = protection_violation_flag_r;
				prdata[ST_MG1] = mg1_r;
				prdata[ST_MG0] = mg0_r;
			end
			OFS_INDEX: prdata[2:0] = idx_r;
			OFS_PARAM: prdata[15:0] = (idx_r <= IDX_LAST) ? param_r[idx_r] : 16'h0000;
			OFS_AVAIL: prdata[2:0] = avail_r;
			OFS_PROT_LO: prdata[17:0] = prot_lo_r;
			OFS_PROT_HI: prdata[17:0] = prot_hi_r;
			OFS_PROT_CTL: prdata[1:0] = prot_ctl_r;
			OFS_SECURITY: prdata[0] = secured_r;
			default: prdata = 32'h00000000;
		endcase
		if (!(acc_phase && !pwrite && hit))
			prdata = 32'h00000000;
	end

	// launch checks, all judged on the write that clears the complete flag
	assign code = param_r[IDX_CODE][15:8];
	assign gaddr = {param_r[0][1:0], param_r[1]};
	assign pf_valid = (gaddr >= PF_LO) && (gaddr <= PF_HI); // R6
	assign prot_hit = prot_ctl_r[PC_PFLASH] && (gaddr >= prot_lo_r) && (gaddr <= prot_hi_r);
	// a pending error blocks a new launch until software clears it
	assign launch = wr_en && ofs == OFS_STATUS && pwdata[ST_CMD_COMPLETE_FLAG] && cmd_complete_flag_r
		&& !access_error_flag_r && !protection_violation_flag_r;

	always_comb
	begin
		chk_acc = 1'b1;
		chk_fpv = 1'b0;
		unique case (code)
			CMD_PROG:
			begin
				chk_acc = idx_r != IDX_LAST || !avail_r[AV_PROG] // R4 R5
					|| !pf_valid || gaddr[2:0] != 3'b000; // R6 R7
				chk_fpv = prot_hit; // R8
			end
			CMD_ONCE:
			begin
				chk_acc = idx_r != IDX_LAST || !avail_r[AV_ONCE] // R4 R5
					|| param_r[1] > ONCE_LAST; // R13
			end
			CMD_ERALL:
			begin
				chk_acc = idx_r != IDX_CODE || !avail_r[AV_ERALL]; // R19 R5
				chk_fpv = prot_ctl_r[PC_PFLASH] | prot_ctl_r[PC_DFLASH]; // R21
			end
			default: chk_acc = 1'b1;
		endcase
	end
	assign launch_ok = launch && !chk_acc && !chk_fpv; // R23

	assign blank_ok = fl_rsp.rdata == ERASED_PHRASE && !fl_rsp.err && !fl_rsp.uncorr; // R15
	assign verify_bad = fl_rsp.rdata != wdata_r || fl_rsp.err || fl_rsp.uncorr;
	assign ever_bad = fl_rsp.err | fl_rsp.uncorr;

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			SQ_IDLE:
				if (launch_ok)
				begin
					if (code == CMD_PROG)
						state_nxt = SQ_PROG; // R3
					else if (code == CMD_ONCE)
						state_nxt = SQ_BLANK; // R12
					else
						state_nxt = SQ_ERASE; // R20
				end
			SQ_BLANK:
				if (fl_rsp.ack)
					state_nxt = blank_ok ? SQ_PROG : SQ_IDLE; // R14
			SQ_PROG:
				if (fl_rsp.ack)
					state_nxt = SQ_VERIFY; // R3
			SQ_VERIFY:
				if (fl_rsp.ack)
					state_nxt = SQ_IDLE;
			SQ_ERASE:
				if (fl_rsp.ack)
					state_nxt = SQ_EVERIFY; // R20
			SQ_EVERIFY:
				if (fl_rsp.ack)
					state_nxt = SQ_IDLE;
			default: state_nxt = SQ_IDLE;
		endcase
		once_nxt = launch_ok ? (code == CMD_ONCE) : once_r;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= SQ_IDLE;
			once_r <= 1'b0;
			cmd_complete_flag_r <= 1'b1;
			pf_read_invalid <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			once_r <= once_nxt;
			cmd_complete_flag_r <= state_nxt == SQ_IDLE; // R3 R12 R23
			pf_read_invalid <= state_nxt != SQ_IDLE && once_nxt; // R16
		end
	end

	// operands are frozen at launch so stray writes cannot disturb a run
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_r <= 18'h00000;
			wdata_r <= 64'h0;
		end
		else if (launch_ok)
		begin
			addr_r <= (code == CMD_ONCE) ? {12'h000, param_r[1][2:0], 3'b000} : gaddr;
			wdata_r <= {param_r[2], param_r[3], param_r[4], param_r[5]};
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			req_r <= '0;
		else
		begin
			req_r.valid <= state_nxt != SQ_IDLE;
			req_r.ifr <= once_nxt;
			req_r.addr <= launch_ok ? gaddr : addr_r;
			req_r.wdata <= wdata_r;
			unique case (state_nxt)
				SQ_PROG: req_r.fop <= FOP_PROG;
				SQ_ERASE: req_r.fop <= FOP_ERASE_ALL;
				SQ_EVERIFY: req_r.fop <= FOP_BLANK_ALL;
				default: req_r.fop <= FOP_READ;
			endcase
			if (launch_ok && code == CMD_ONCE)
				req_r.addr <= {12'h000, param_r[1][2:0], 3'b000};
			if (launch_ok)
				req_r.wdata <= {param_r[2], param_r[3], param_r[4], param_r[5]};
		end
	end
	assign fl_req = req_r;

	// error flags: set wins over a write-one clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			access_error_flag_r <= 1'b0;
			protection_violation_flag_r <= 1'b0;
		end
		else
		begin
			if (launch && chk_acc)
				access_error_flag_r <= 1'b1; // R4 R5 R6 R7 R13 R19
			else if (state_r == SQ_BLANK && fl_rsp.ack && fl_rsp.rdata != ERASED_PHRASE)
				access_error_flag_r <= 1'b1; // R14
			else if (wr_en && ofs == OFS_STATUS && pwdata[ST_ACCESS_ERROR_FLAG])
				access_error_flag_r <= 1'b0;
			if (launch && chk_fpv)
				protection_violation_flag_r <= 1'b1; // R8 R21
			else if (wr_en && ofs == OFS_STATUS && pwdata[ST_PROTECTION_VIOLATION_FLAG])
				protection_violation_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mg1_r <= 1'b0;
			mg0_r <= 1'b0;
		end
		else if (launch)
		begin
			mg1_r <= 1'b0;
			mg0_r <= 1'b0;
		end
		else if (fl_rsp.ack)
		begin
			if ((state_r == SQ_VERIFY && verify_bad) || (state_r == SQ_EVERIFY && ever_bad)
				|| (state_r == SQ_BLANK && ever_bad))
				mg1_r <= 1'b1; // R9
			if (state_r != SQ_PROG && state_r != SQ_ERASE && fl_rsp.uncorr)
				mg0_r <= 1'b1; // R10
		end
	end

	// only a clean whole-space verify unlocks
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			secured_r <= 1'b1;
		else if (state_r == SQ_EVERIFY && fl_rsp.ack && !ever_bad)
			secured_r <= 1'b0; // R20
	end
	assign secured = secured_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			idx_r <= 3'h0;
			avail_r <= AVAIL_RST;
			prot_lo_r <= PROT_LO_RST;
			prot_hi_r <= PROT_HI_RST;
			prot_ctl_r <= PROT_CTL_RST;
		end
		else if (wr_en && cmd_complete_flag_r)
		begin
			unique case (ofs)
				OFS_INDEX: idx_r <= pwdata[2:0];
				OFS_AVAIL: avail_r <= pwdata[2:0];
				OFS_PROT_LO: prot_lo_r <= pwdata[17:0];
				OFS_PROT_HI: prot_hi_r <= pwdata[17:0];
				OFS_PROT_CTL: prot_ctl_r <= pwdata[1:0];
				default: idx_r <= idx_r;
			endcase
		end
	end

	for (genvar g = 0; g < PARAM_WORDS; g++)
	begin : g_param
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				param_r[g] <= 16'h0000;
			else if (wr_en && cmd_complete_flag_r && ofs == OFS_PARAM && idx_r == 3'(g))
				param_r[g] <= pwdata[15:0];
		end
	end

	a_launch_busy: assert property (@(posedge pclk) disable iff (!presetn)
		launch_ok |=> !cmd_complete_flag_r && fl_req.valid) else $error("launch did not start"); // R3
	a_prog_index: assert property (@(posedge pclk) disable iff (!presetn)
		launch && code == CMD_PROG && idx_r != IDX_LAST |=> access_error_flag_r && cmd_complete_flag_r)
		else $error("bad index not flagged"); // R4
	a_mode_gate: assert property (@(posedge pclk) disable iff (!presetn)
		launch && code == CMD_ERALL && !avail_r[AV_ERALL] |=> access_error_flag_r)
		else $error("unavailable command not flagged"); // R5
	a_addr_range: assert property (@(posedge pclk) disable iff (!presetn)
		launch && code == CMD_PROG && (!pf_valid || gaddr[2:0] != 3'b000) |=> access_error_flag_r)
		else $error("bad program address not flagged"); // R6
	a_prot_hit: assert property (@(posedge pclk) disable iff (!presetn)
		launch && code == CMD_PROG && prot_hit |=> protection_violation_flag_r && state_r == SQ_IDLE)
		else $error("protected program not refused"); // R8
	a_verify_fail: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == SQ_VERIFY && fl_rsp.ack && fl_rsp.rdata != wdata_r |=> mg1_r && cmd_complete_flag_r)
		else $error("verify mismatch missed"); // R9
	a_uncorr_flag: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == SQ_EVERIFY && fl_rsp.ack && fl_rsp.uncorr |=> mg0_r && mg1_r && secured_r)
		else $error("uncorrectable error missed"); // R10
	a_once_blank: assert property (@(posedge pclk) disable iff (!presetn)
		launch_ok && code == CMD_ONCE |=> state_r == SQ_BLANK && !cmd_complete_flag_r && pf_read_invalid)
		else $error("write-once did not blank check"); // R12
	a_once_refuse: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == SQ_BLANK && fl_rsp.ack && fl_rsp.rdata != ERASED_PHRASE
		|=> access_error_flag_r && state_r == SQ_IDLE) else $error("second write-once allowed"); // R14
	a_once_rerun: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == SQ_BLANK && fl_rsp.ack && blank_ok |=> state_r == SQ_PROG)
		else $error("erased phrase refused"); // R15
	a_erall_index: assert property (@(posedge pclk) disable iff (!presetn)
		launch && code == CMD_ERALL && idx_r != IDX_CODE |=> access_error_flag_r)
		else $error("erase index not flagged"); // R19
	a_unsecure: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == SQ_EVERIFY && fl_rsp.ack && !ever_bad |=> !secured_r && cmd_complete_flag_r)
		else $error("security not released"); // R20
	a_no_start: assert property (@(posedge pclk) disable iff (!presetn)
		launch && (chk_acc || chk_fpv) |=> cmd_complete_flag_r && !fl_req.valid)
		else $error("errored launch started"); // R23
endmodule
`default_nettype wire

/* File: fpec_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import fpec_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pf_read_invalid;
	logic secured;
	fpec_freq_t fl_req;
	fpec_frsp_t fl_rsp = '0;
	logic [63:0] mem = 64'h0;
	logic [63:0] flip = 64'h0;
	logic [63:0] pd = 64'h0123_4567_89ab_cdef;
	logic f_err = 1'b0;
	logic f_unc = 1'b0;
	logic [31:0] q;
	logic slv;
	logic [15:0] codes [3] = '{16'h0603, 16'h0700, 16'h0800};
	int lat = 1;
	int cnt = 0;
	int err_count = 0;
	int check_count = 0;

	always #2 pclk = ~pclk;

	fpec_seq u_fpec_seq (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fl_req(fl_req), .fl_rsp(fl_rsp),
		.pf_read_invalid(pf_read_invalid), .secured(secured));

	// flash array stand-in; rdata churns between acks so stale data never looks valid
	always @(posedge pclk)
	begin
		if (fl_req.valid === 1'b1 && fl_rsp.ack === 1'b0 && cnt >= lat)
		begin
			cnt <= 0;
			fl_rsp <= '{1'b1, mem, f_err, f_unc};
			if (fl_req.fop == FOP_PROG)
				mem <= fl_req.wdata ^ flip;
		end
		else
		begin
			fl_rsp.ack <= 1'b0;
			fl_rsp.rdata <= ~fl_rsp.rdata;
			if (fl_req.valid === 1'b1 && fl_rsp.ack === 1'b0)
				cnt <= cnt + 1;
		end
	end

	task stop_test;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// answer and read data are taken at the rising edge that completes the access
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		logic rdy;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			q = prdata;
			slv = pslverr;
			rdy = pready;
			n++;
		end while (rdy !== 1'b1 && n < 100);
		if (rdy !== 1'b1)
			err_count++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task put(input logic [2:0] i, input logic [15:0] v);
		wr(OFS_INDEX, {29'h0, i});
		wr(OFS_PARAM, {16'h0, v});
	endtask

	task load(input logic [15:0] c, input logic [15:0] a, input logic [63:0] d);
		put(3'h0, c);
		put(3'h1, a);
		put(3'h2, d[63:48]);
		put(3'h3, d[47:32]);
		put(3'h4, d[31:16]);
		put(3'h5, d[15:0]);
	endtask

	task go(input logic v);
		wr(OFS_STATUS, 32'h80);
		@(negedge pclk);
		chk("req_valid", fl_req.valid, v);
	endtask

	task fin(input logic [7:0] st, input string nm);
		int n;
		@(posedge pclk);
		n = 0;
		do
		begin
			rd(OFS_STATUS);
			n++;
		end while (q[7] !== 1'b1 && n < 500);
		chk(nm, q, {24'h0, st});
		wr(OFS_STATUS, 32'h30);
		$display("test %s done", nm);
	endtask

	initial
	begin
		#100000;
		err_count++;
		$display("watchdog expired");
		stop_test;
	end

	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFS_STATUS);
		chk("status_rst", q, 32'h80);
		rd(OFS_AVAIL);
		chk("avail_rst", q, {29'h0, AVAIL_RST});
		rd(OFS_PROT_CTL);
		chk("prot_ctl_rst", q, {30'h0, PROT_CTL_RST});
		rd(OFS_SECURITY);
		chk("security_rst", q, 32'h1);
		rd(8'h40);
		chk("unmapped_err", slv, 1'b1);
		flip = 64'h1;
		load(16'h0603, 16'h0008, pd);
		go(1'b1);
		fin(8'h82, "prog_verify");
		flip = 64'h0;
		f_unc = 1'b1;
		load(16'h0603, 16'h0008, pd);
		go(1'b1);
		fin(8'h83, "prog_uncorr");
		f_unc = 1'b0;
		lat = 5;
		load(16'h0603, 16'h0008, pd);
		go(1'b1);
		chk("prog_fop", fl_req.fop, FOP_PROG);
		chk("prog_addr", fl_req.addr, 18'h30008);
		chk("prog_data", fl_req.wdata, pd);
		fin(8'h80, "prog_ok");
		lat = 1;
		load(16'h0603, 16'h0008, pd);
		wr(OFS_INDEX, 32'h4);
		go(1'b0);
		fin(8'ha0, "prog_index");
		load(16'h0603, 16'h0004, pd);
		go(1'b0);
		fin(8'ha0, "prog_align");
		load(16'h0601, 16'h0008, pd);
		go(1'b0);
		fin(8'ha0, "prog_range");
		wr(OFS_PROT_LO, 32'h30000);
		wr(OFS_PROT_HI, 32'h30fff);
		wr(OFS_PROT_CTL, 32'h1);
		load(16'h0603, 16'h0008, pd);
		go(1'b0);
		fin(8'h90, "prog_prot");
		wr(OFS_PROT_CTL, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			wr(OFS_AVAIL, 32'h0);
			load(codes[i], 16'h0000, ERASED_PHRASE);
			if (i == 2)
				wr(OFS_INDEX, 32'h0);
			go(1'b0);
			fin(8'ha0, "mode_off");
			wr(OFS_AVAIL, 32'h7);
		end
		load(16'h0700, 16'h0008, pd);
		go(1'b0);
		fin(8'ha0, "once_range");
		mem = ERASED_PHRASE;
		load(16'h0700, 16'h0003, pd);
		go(1'b1);
		chk("once_ifr", fl_req.ifr, 1'b1);
		chk("once_fop", fl_req.fop, FOP_READ);
		chk("once_addr", fl_req.addr, 18'h18);
		chk("rd_invalid", pf_read_invalid, 1'b1);
		fin(8'h80, "once_ok");
		chk("rd_valid", pf_read_invalid, 1'b0);
		load(16'h0700, 16'h0003, pd);
		go(1'b1);
		fin(8'ha0, "once_twice");
		chk("once_kept", mem, pd);
		mem = ERASED_PHRASE;
		for (int i = 0; i < 2; i++)
		begin
			load(16'h0700, 16'h0005, ERASED_PHRASE);
			go(1'b1);
			fin(8'h80, "once_ones");
		end
		put(3'h0, 16'h0800);
		wr(OFS_INDEX, 32'h1);
		go(1'b0);
		fin(8'ha0, "erase_index");
		wr(OFS_PROT_CTL, 32'h2);
		put(3'h0, 16'h0800);
		go(1'b0);
		fin(8'h90, "erase_prot");
		wr(OFS_PROT_CTL, 32'h0);
		f_err = 1'b1;
		put(3'h0, 16'h0800);
		go(1'b1);
		chk("erase_fop", fl_req.fop, FOP_ERASE_ALL);
		fin(8'h82, "erase_bad");
		chk("still_secured", secured, 1'b1);
		f_err = 1'b0;
		f_unc = 1'b1;
		put(3'h0, 16'h0800);
		go(1'b1);
		fin(8'h83, "erase_uncorr");
		chk("uncorr_secured", secured, 1'b1);
		f_unc = 1'b0;
		put(3'h0, 16'h0800);
		go(1'b1);
		fin(8'h80, "erase_ok");
		chk("unsecured", secured, 1'b0);
		rd(OFS_SECURITY);
		chk("security_reg", q, 32'h0);
		stop_test;
	end
endmodule
`default_nettype wire
